// ---- core/nvh_host.sv ----
// Host controller driving a byte-wide memory with nonvolatile save/restore
`timescale 1ns/1ns
`include "nvh_consts.svh"
module nvh_host (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Host request and answer
  input  wire logic            req_valid,
  input  wire nvh_pkg::nvh_req_s req,
  output logic                 req_ready,
  output logic                 rsp_valid,
  output logic [7:0]           rsp_rdata,
  // Memory control and address pins
  output logic                 mem_ce_n,
  output logic                 mem_oe_n,
  output logic                 mem_we_n,
  output logic [14:0]          mem_addr,
  // Memory data pins
  input  wire logic [7:0]      data_pins_i,
  output logic [7:0]           data_pins_o,
  output logic                 data_pins_oe_n,
  // Busy pin, open drain
  input  wire logic            store_busy_n_i,
  output logic                 store_busy_n_o,
  output logic                 store_busy_n_oe_n,
  // Strap: holdup capacitor fitted
  input  wire logic            cap_fitted
);
  import nvh_pkg::*;
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  nvh_state_e  state_reg;
  nvh_op_e     op_reg;
  logic [14:0] uaddr_reg;
  logic [7:0]  wdata_reg;
  logic [3:0]  cnt_reg;
  logic [2:0]  idx_reg;
  logic        internal_reg;
  logic        boot_done_reg;
  logic [1:0]  age_reg;
  logic [7:0]  dq_meta_reg;
  logic [7:0]  dq_sync_reg;
  logic        busy_meta_reg;
  logic        busy_sync_reg;
  logic        cap_meta_reg;
  logic        cap_sync_reg;
  logic        is_seq;
  logic        is_wr;
  logic [14:0] cur_addr;
  // Command sequence address for a step of a given command
  function automatic logic [14:0] seq_addr(input logic [2:0] idx,
                                           input nvh_op_e op);
    logic [14:0] a;
    a = `NVH_SEQ_A0;
    unique case (idx)
      3'h0: a = `NVH_SEQ_A0;
      3'h1: a = `NVH_SEQ_A1;
      3'h2: a = `NVH_SEQ_A2;
      3'h3: a = `NVH_SEQ_A3;
      3'h4: a = `NVH_SEQ_A4;
      default: begin
        unique case (op)
          OP_SAVE:    a = `NVH_SEQ_STORE;
          OP_RESTORE: a = `NVH_SEQ_RECALL;
          OP_PF_OFF:  a = `NVH_SEQ_PF_OFF;
          default:    a = `NVH_SEQ_PF_ON;
        endcase
      end
    endcase
    return a;
  endfunction
  // Command decode
  assign is_seq   = (op_reg == OP_SAVE) || (op_reg == OP_RESTORE) ||
                    (op_reg == OP_PF_OFF) || (op_reg == OP_PF_ON);
  assign is_wr    = (op_reg == OP_WRITE);
  assign cur_addr = is_seq ? seq_addr(idx_reg, op_reg) : uaddr_reg;
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Two flops on every pin input
  always_ff @(posedge clk) begin
    dq_meta_reg   <= data_pins_i;
    dq_sync_reg   <= dq_meta_reg;
    busy_meta_reg <= store_busy_n_i;
    busy_sync_reg <= busy_meta_reg;
    cap_meta_reg  <= cap_fitted;
    cap_sync_reg  <= cap_meta_reg;
  end
  // Age counter so the strap is read only once the synchroniser is full
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  // ------------------------------------------------------------
  // Access sequencer and pins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg         <= ST_IDLE;
      op_reg            <= OP_READ;
      uaddr_reg         <= 15'h0000;
      wdata_reg         <= 8'h00;
      cnt_reg           <= 4'h0;
      idx_reg           <= 3'h0;
      internal_reg      <= 1'b0;
      boot_done_reg     <= 1'b0;
      req_ready         <= 1'b0;
      rsp_valid         <= 1'b0;
      rsp_rdata         <= 8'h00;
      mem_ce_n          <= 1'b1;
      mem_oe_n          <= 1'b1;
      mem_we_n          <= 1'b1;
      mem_addr          <= 15'h0000;
      data_pins_o       <= 8'h00;
      data_pins_oe_n    <= 1'b1;
      store_busy_n_o    <= 1'b0;
      store_busy_n_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          data_pins_oe_n <= 1'b1;  // Write data outlives the strobe a cycle
          cnt_reg <= 4'h0;
          idx_reg <= 3'h0;
          // No access while the memory reports busy
          if (busy_sync_reg && !boot_done_reg && age_reg == 2'h3) begin
            boot_done_reg <= 1'b1;
            if (!cap_sync_reg) begin
              op_reg       <= OP_PF_OFF;
              internal_reg <= 1'b1;
              state_reg    <= ST_SETUP;
            end
          end else if (busy_sync_reg && req_valid && req_ready) begin
            op_reg       <= req.op;
            uaddr_reg    <= req.addr;
            wdata_reg    <= req.wdata;
            internal_reg <= 1'b0;
            state_reg    <= (req.op == OP_HW_SAVE) ? ST_PULSE : ST_SETUP;
          end else begin
            req_ready <= busy_sync_reg && boot_done_reg;
          end
        end
        ST_SETUP: begin
          // Address and write data settle before the strobe
          mem_ce_n       <= 1'b0;
          mem_oe_n       <= 1'b1;
          mem_we_n       <= 1'b1;
          mem_addr       <= cur_addr;
          data_pins_o    <= wdata_reg;
          data_pins_oe_n <= !is_wr;
          if (cnt_reg == 4'(`NVH_SETUP_CYC - 1)) begin
            cnt_reg   <= 4'h0;
            state_reg <= ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_STROBE: begin
          // Output drive stays high for writes
          mem_oe_n <= is_wr;
          mem_we_n <= !is_wr;
          if (cnt_reg == 4'(`NVH_STROBE_CYC - 1)) begin
            cnt_reg   <= 4'h0;
            state_reg <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_HOLD: begin
          // Closing edge: strobes rise, address and data held
          mem_ce_n <= 1'b1;
          mem_oe_n <= 1'b1;
          mem_we_n <= 1'b1;
          if (cnt_reg == 4'(`NVH_HOLD_CYC - 1)) begin
            rsp_rdata      <= dq_sync_reg;  // Pins two edges back
            cnt_reg        <= 4'h0;
            if (is_seq && idx_reg != `NVH_SEQ_LAST) begin
              idx_reg   <= idx_reg + 3'h1;
              state_reg <= ST_SETUP;
            end else if (is_seq) begin
              state_reg <= ST_SETTLE;
            end else begin
              rsp_valid <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_PULSE: begin
          // Pull the busy pin low to request a hardware save
          store_busy_n_oe_n <= 1'b0;
          if (cnt_reg == 4'(`NVH_HWPULSE_CYC - 1)) begin
            store_busy_n_oe_n <= 1'b1;
            cnt_reg           <= 4'h0;
            state_reg         <= ST_SETTLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_SETTLE: begin
          // Give the memory time to pull busy low before polling it
          if (cnt_reg == 4'(`NVH_SETTLE_CYC - 1)) begin
            cnt_reg   <= 4'h0;
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_WAIT: begin
          // Done once the memory releases busy
          if (busy_sync_reg) begin
            rsp_valid <= !internal_reg;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence write_strobe_s;
    !mem_we_n && !mem_ce_n;
  endsequence
  sequence write_close_s;
    $rose(mem_we_n);
  endsequence
  no_oe_write_a: assert property (
    !mem_we_n |-> mem_oe_n)
    else $error("output drive low during write");
  wr_addr_hold_a: assert property (
    write_strobe_s |=> $stable(mem_addr) || mem_we_n)
    else $error("write address moved during strobe");
  wr_data_valid_a: assert property (
    write_close_s |-> !data_pins_oe_n && data_pins_o == wdata_reg)
    else $error("write data not driven at closing edge");
  strobe_len_a: assert property (
    $fell(mem_we_n) |-> (!mem_we_n)[*3] ##1 mem_we_n)
    else $error("write strobe width wrong");
  busy_gate_a: assert property (
    $fell(mem_ce_n) && idx_reg == 3'h0 |-> $past(busy_sync_reg, 2))
    else $error("access started while busy");
  we_reset_a: assert property (
    state_reg == ST_IDLE |-> mem_we_n)
    else $error("write strobe active while idle");
  hw_pulse_a: assert property (
    $fell(store_busy_n_oe_n) |-> (!store_busy_n_oe_n)[*8]
      ##[1:3] store_busy_n_oe_n)
    else $error("busy request pulse length wrong");
  seq_read_a: assert property (
    is_seq && state_reg == ST_STROBE && cnt_reg != 4'h0
      |-> mem_we_n && !mem_oe_n)
    else $error("sequence step was not a read");
  seq_addr_a: assert property (
    state_reg == ST_STROBE && op_reg == OP_SAVE && idx_reg == 3'h5
      |-> mem_addr == `NVH_SEQ_STORE)
    else $error("save sequence ended at wrong address");
  boot_off_a: assert property (
    $rose(boot_done_reg) && !cap_sync_reg |=> op_reg == OP_PF_OFF)
    else $error("power-fail save not disabled without capacitor");
endmodule

// ---- core/nvh_consts.svh ----
// Timing counts and pin constants for the nonvolatile memory host controller
`ifndef NVH_CONSTS_SVH
`define NVH_CONSTS_SVH

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define NVH_CLK_NS        50

// ------------------------------------------------------------
// Bus phase times in ns, and their cycle counts (rounded up)
// ------------------------------------------------------------
`define NVH_SETUP_NS      50
`define NVH_STROBE_NS     150
`define NVH_HOLD_NS       50
`define NVH_HWPULSE_NS    500
`define NVH_SETTLE_NS     500
`define NVH_SETUP_CYC   ((`NVH_SETUP_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_STROBE_CYC  ((`NVH_STROBE_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_HOLD_CYC    ((`NVH_HOLD_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_HWPULSE_CYC ((`NVH_HWPULSE_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_SETTLE_CYC  ((`NVH_SETTLE_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)

// ------------------------------------------------------------
// Command sequence addresses
// ------------------------------------------------------------
`define NVH_SEQ_A0        15'h0E38
`define NVH_SEQ_A1        15'h31C7
`define NVH_SEQ_A2        15'h03E0
`define NVH_SEQ_A3        15'h3C1F
`define NVH_SEQ_A4        15'h303F
`define NVH_SEQ_STORE     15'h0FC0
`define NVH_SEQ_RECALL    15'h0C63
`define NVH_SEQ_PF_OFF    15'h0B45
`define NVH_SEQ_PF_ON     15'h0B46
`define NVH_SEQ_LAST      3'h5

`endif

// ---- core/nvh_pkg.sv ----
// Types shared by the nonvolatile memory host controller
package nvh_pkg;

  // Host command codes
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_WRITE     = 3'h1,
    OP_SAVE      = 3'h2,
    OP_RESTORE   = 3'h3,
    OP_PF_OFF    = 3'h4,
    OP_PF_ON     = 3'h5,
    OP_HW_SAVE   = 3'h6
  } nvh_op_e;

  // One host request
  typedef struct packed {
    nvh_op_e     op;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } nvh_req_s;

  // Controller states, Gray coded along the access path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD   = 3'h2,
    ST_SETTLE = 3'h6,
    ST_WAIT   = 3'h7,
    ST_PULSE  = 3'h4
  } nvh_state_e;

endpackage

// ---- tb/nvh_mem_model.sv ----
// Behavioural model of the byte-wide memory with a nonvolatile shadow
`timescale 1ns/1ns

module nvh_mem_model #(
  parameter int SAVE_NS = 2000
) (
  // Strobes and address
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [14:0] addr,
  // Data pins
  input  wire logic [7:0]  dq,
  input  wire logic        host_drv,
  output logic [7:0]       dq_out,
  // Busy pin and supply monitor
  input  wire logic        busy_pull,
  output logic             busy,
  input  wire logic        pf,
  // Observation
  output logic [7:0]       save_cnt,
  output logic             pf_en,
  output logic [7:0]       viol
);
  logic [7:0]  sram [0:32767];
  logic [7:0]  nvm  [0:32767];
  logic [7:0]  last = 8'h00;
  logic        dev_low = 1'b0;
  logic        pending = 1'b0;
  logic [2:0]  step = 3'h0;
  logic        rd_act;
  logic        wr_act;
  logic [14:0] pre [0:4] = '{15'h0E38, 15'h31C7, 15'h03E0, 15'h3C1F,
                             15'h303F};

  // Power-up state
  initial begin
    for (int i = 0; i < 32768; i++) begin
      sram[i] = 8'h00;
      nvm[i] = 8'h00;
    end
    save_cnt = 8'h00;
    pf_en = 1'b1;
    viol = 8'h00;
  end

  // Pull-up unless someone pulls low; brief high drive gives same level
  assign busy = !(dev_low || busy_pull);
  assign rd_act = !ce_n && !oe_n && we_n && busy;
  assign wr_act = !ce_n && !we_n && busy;
  // Released pins show the inverse of the last byte, never a stale copy
  assign dq_out = rd_act ? sram[addr] : ~last;
  always @(rd_act or addr) if (rd_act) last = sram[addr];

  // Whole array copied in one go while busy is held low
  task automatic save;
    dev_low = 1'b1;
    #SAVE_NS;
    nvm = sram;
    pending = 1'b0;
    save_cnt = save_cnt + 8'h01;
    dev_low = 1'b0;
  endtask

  // Write lands at the closing edge and breaks any sequence
  always @(negedge wr_act) begin
    sram[addr] = dq;
    pending = 1'b1;
    step = 3'h0;
  end

  // Host misbehaviour is counted
  always @(addr) if (wr_act) viol = viol + 8'h01;
  always @(rd_act or host_drv) if (rd_act && host_drv) viol = viol + 8'h01;
  always @(negedge ce_n) if (!busy) viol = viol + 8'h01;

  // Sequence decoder on each finished read
  always @(negedge rd_act) begin
    if (step == 3'h5) begin
      step = 3'h0;
      case (addr)
        15'h0FC0: save();
        15'h0C63: begin
          dev_low = 1'b1;
          #SAVE_NS;
          sram = nvm;
          pending = 1'b0;
          dev_low = 1'b0;
        end
        15'h0B45: pf_en = 1'b0;
        15'h0B46: pf_en = 1'b1;
        default: ;
      endcase
    end else if (addr == pre[step]) step = step + 3'h1;
    else step = (addr == pre[0]) ? 3'h1 : 3'h0;
  end

  // Pin request and power failure save only when something was written
  always @(posedge busy_pull) if (pending && !dev_low) save();
  always @(posedge pf) begin
    if (pf_en && pending && !dev_low) save();
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking testbench of the nonvolatile memory host controller
`timescale 1ns/1ns

module tb;
  import nvh_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        req_valid;
  nvh_req_s    req;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_rdata;
  logic        mem_ce_n;
  logic        mem_oe_n;
  logic        mem_we_n;
  logic [14:0] mem_addr;
  logic [7:0]  data_pins_i;
  logic [7:0]  data_pins_o;
  logic        data_pins_oe_n;
  logic [7:0]  mem_dq;
  logic        busy_lvl;
  logic        store_busy_n_o;
  logic        store_busy_n_oe_n;
  logic        cap_fitted;
  logic        pf;
  logic [7:0]  save_cnt;
  logic        pf_en;
  logic [7:0]  viol;
  int          failures = 0;
  int          comparisons = 0;

  // Data wire level from whichever side drives
  assign data_pins_i = !data_pins_oe_n ? data_pins_o : mem_dq;

  nvh_host i_nvh_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_addr(mem_addr), .data_pins_i(data_pins_i),
    .data_pins_o(data_pins_o), .data_pins_oe_n(data_pins_oe_n),
    .store_busy_n_i(busy_lvl), .store_busy_n_o(store_busy_n_o),
    .store_busy_n_oe_n(store_busy_n_oe_n), .cap_fitted(cap_fitted));

  nvh_mem_model i_nvh_mem_model (.ce_n(mem_ce_n), .oe_n(mem_oe_n),
    .we_n(mem_we_n), .addr(mem_addr), .dq(data_pins_i),
    .host_drv(!data_pins_oe_n), .dq_out(mem_dq),
    .busy_pull(!store_busy_n_oe_n && !store_busy_n_o),
    .busy(busy_lvl), .pf(pf),
    .save_cnt(save_cnt), .pf_en(pf_en), .viol(viol));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One command: wait ready, offer, wait for the answer pulse
  task automatic cmd(input nvh_op_e op, input logic [14:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) failures++;
    req_valid <= 1'b1;
    req <= '{op, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 4000);
    if (n >= 4000) failures++;
    q = rsp_rdata;
  endtask

  task automatic pulse_pf;
    pf <= 1'b1;
    repeat (60) @(posedge clk);
    pf <= 1'b0;
    @(posedge clk);
  endtask

  // Corner addresses and one mid-range address written, then all read back
  task automatic t_rw;
    logic [7:0]  q;
    logic [14:0] al [3] = '{15'h0000, 15'h7FFF, 15'h4AB5};
    logic [7:0]  dv [3] = '{8'h3C, 8'hC3, 8'h96};
    foreach (al[i]) cmd(OP_WRITE, al[i], dv[i], q);
    foreach (al[i]) begin
      cmd(OP_READ, al[i], 8'h00, q);
      check(q, dv[i]);
    end
  endtask

  // Software save, overwrite, restore, then save with nothing written
  task automatic t_sw;
    logic [7:0] q;
    logic [7:0] sc;
    cmd(OP_WRITE, 15'h0100, 8'h5A, q);
    cmd(OP_SAVE, 15'h0000, 8'h00, q);
    cmd(OP_WRITE, 15'h0100, 8'hA5, q);
    cmd(OP_RESTORE, 15'h0000, 8'h00, q);
    cmd(OP_READ, 15'h0100, 8'h00, q);
    check(q, 8'h5A);
    sc = save_cnt;
    cmd(OP_SAVE, 15'h0000, 8'h00, q);
    check(save_cnt, sc + 8'h01);
  endtask

  // Pin save skipped when clean, executed after a write
  task automatic t_hw;
    logic [7:0] q;
    logic [7:0] sc;
    sc = save_cnt;
    cmd(OP_HW_SAVE, 15'h0000, 8'h00, q);
    check(save_cnt, sc);
    cmd(OP_WRITE, 15'h0200, 8'h77, q);
    cmd(OP_HW_SAVE, 15'h0000, 8'h00, q);
    check(save_cnt, sc + 8'h01);
  endtask

  // Power failure save follows the enable set by the sequences
  task automatic t_pf;
    logic [7:0] q;
    logic [7:0] sc;
    check({7'h00, pf_en}, 8'h01);
    cmd(OP_WRITE, 15'h0300, 8'h11, q);
    cmd(OP_PF_OFF, 15'h0000, 8'h00, q);
    check({7'h00, pf_en}, 8'h00);
    sc = save_cnt;
    pulse_pf;
    check(save_cnt, sc);
    cmd(OP_PF_ON, 15'h0000, 8'h00, q);
    check({7'h00, pf_en}, 8'h01);
    pulse_pf;
    check(save_cnt, sc + 8'h01);
  endtask

  // Boot without holdup capacitor turns power failure save off
  task automatic t_nocap;
    logic [7:0] q;
    cap_fitted <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cmd(OP_READ, 15'h0100, 8'h00, q);
    check(q, 8'h5A);
    check({7'h00, pf_en}, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    cap_fitted = 1'b1;
    pf = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_rw;
    t_sw;
    t_hw;
    t_pf;
    t_nocap;
    check(viol, 8'h00);
    end_sim;
  end

  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    failures++;
    end_sim;
  end
endmodule
